// ---- dv/amt_keypad_model.sv ----
/*
  Keypad model: presses one key at a time as a clean level pulse.
  Assumes the bench raises start_i for one cycle and waits for done_o.
*/
`timescale 1ns/1ps
module amt_keypad_model (
  input  wire logic       core_clk_i,
  input  wire logic       start_i,
  input  wire logic [2:0] key_sel_i,
  input  wire logic       slow_i,
  output logic      [4:0] keys_o,
  output logic            done_o
);
  int cnt = 0;
  initial keys_o = 5'h00;
  initial done_o = 1'b0;
  // Release well before done so the next press gives a fresh rising edge
  always @(posedge core_clk_i) begin
    done_o <= 1'b0;
    if (start_i && cnt == 0) begin
      keys_o <= 5'h01 << key_sel_i;
      cnt    <= slow_i ? 30 : 14;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 8) keys_o <= 5'h00;
      if (cnt == 1) done_o <= 1'b1;
    end
  end
endmodule : amt_keypad_model

// ---- dv/tb.sv ----
/*
  Self-checking bench for the analog monitor trim block.
  Assumes the keypad model in amt_keypad_model and a short done time.
*/
`timescale 1ns/1ps
module tb;
  localparam int DONE_CYC = 20;
  localparam logic [2:0] K_UP = 3'h0, K_DN = 3'h1, K_SCR = 3'h2, K_DATA = 3'h3, K_MODE = 3'h4;
  logic        clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, pinit = 1'b0, start = 1'b0, slow = 1'b0;
  logic [3:0]  addr = 4'h0, wp = 4'h0;
  logic [7:0]  wdata = 8'h00, rdata, f_ofs, s_ofs;
  logic [10:0] f_gain, s_gain;
  logic [2:0]  ksel = 3'h0;
  logic [4:0]  keys;
  logic [1:0]  fn;
  logic        active, cursor, done, bb, commit, kdone;
  int          n_fail = 0, n_tests = 0, n_commit = 0, n_done = 0, n_inv = 0;

  always #20 clk = ~clk;

  amt_trim #(.DONE_CYCLES(DONE_CYC)) DUT (
    .core_clk_i(clk), .nrst_i(nrst), .key_up_i(keys[0]), .key_down_i(keys[1]),
    .key_scroll_i(keys[2]), .key_data_i(keys[3]), .key_modeset_i(keys[4]),
    .write_protect_setting_i(wp), .parameter_init_i(pinit), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .force_offset_o(f_ofs), .speed_offset_o(s_ofs),
    .force_gain_permil_o(f_gain), .speed_gain_permil_o(s_gain), .edit_active_o(active),
    .edit_function_o(fn), .cursor_o(cursor), .done_indication_o(done),
    .base_block_indication_o(bb), .commit_pulse_o(commit));

  amt_keypad_model KPD (.core_clk_i(clk), .start_i(start), .key_sel_i(ksel), .slow_i(slow),
                        .keys_o(keys), .done_o(kdone));

  always @(posedge clk) begin
    if (commit === 1'b1) n_commit++;
    if (done === 1'b1) n_done++;
    if (nrst === 1'b1 && done === bb) n_inv++;
  end

  task automatic test_done();
    if (n_fail == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic press(input logic [2:0] k, input int n);
    int i;
    repeat (n) begin
      ksel  <= k;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      i = 0;
      do begin
        @(posedge clk);
        i++;
      end while (kdone !== 1'b1 && i < 100);
      if (i >= 100) n_fail++;
    end
  endtask : press

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    // Read data stand only in the cycle after the strobe
    #1 check(rdata, exp);
    @(posedge clk);
  endtask : reg_rd

  // Commit, then wait out the completion indication under a bound
  task automatic commit_wait();
    int i;
    n_commit = 0;
    n_done = 0;
    press(K_DATA, 1);
    for (i = 0; i < 100 && done === 1'b1; i++) @(posedge clk);
    check(n_done, DONE_CYC);
    check(n_commit, 1);
    check(bb, 1'b1);
  endtask : commit_wait

  task automatic t_reset();
    check(f_ofs, amt_pkg::OFS1_FACTORY);
    check(s_ofs, amt_pkg::OFS2_FACTORY);
    check(f_gain, 11'h3e8);
    check(s_gain, 11'h3e8);
    check({bb, done, active}, 3'h4);
    reg_rd(amt_pkg::ADDR_GAIN2, amt_pkg::GAIN2_FACTORY);
    reg_rd(4'h9, 8'h00);
  endtask : t_reset

  task automatic t_refuse();
    wp <= 4'h1;
    reg_wr(amt_pkg::ADDR_CTRL, 8'h01);
    press(K_DATA, 1);
    check(active, 1'b0);
    reg_rd(amt_pkg::ADDR_CTRL, 8'h81);
    reg_wr(amt_pkg::ADDR_CTRL, 8'h81);
    reg_rd(amt_pkg::ADDR_CTRL, 8'h01);
    wp <= amt_pkg::WRITE_PERMIT_CODE;
  endtask : t_refuse

  task automatic t_offset();
    press(K_DATA, 1);
    check({active, fn}, 3'h5);
    check(cursor, 1'b0);
    press(K_UP, 2);
    press(K_DN, 1);
    check(f_ofs, 8'h01);
    reg_rd(amt_pkg::ADDR_OFS1, 8'h01);
    press(K_SCR, 1);
    check(cursor, 1'b1);
    slow <= 1'b1;
    press(K_DN, 130);
    slow <= 1'b0;
    check(s_ofs, 8'h81);
    check(f_ofs, 8'h01);
    commit_wait();
    check(n_inv, 0);
    press(K_MODE, 1);
    check({active, fn}, 3'h0);
    // Pulse init from the menu, where the trim values are at rest
    pinit <= 1'b1;
    @(posedge clk);
    pinit <= 1'b0;
    repeat (4) @(posedge clk);
    check({f_ofs, s_ofs}, 16'h0181);
  endtask : t_offset

  task automatic t_gain();
    reg_wr(amt_pkg::ADDR_CTRL, 8'h02);
    press(K_DATA, 1);
    check({active, fn}, 3'h6);
    check(cursor, 1'b0);
    press(K_UP, 127);
    check(f_gain, 11'h5dc);
    reg_rd(amt_pkg::ADDR_GAIN1, 8'h7d);
    press(K_SCR, 1);
    reg_rd(amt_pkg::ADDR_STATUS, 8'h0e);
    press(K_DN, 127);
    check(s_gain, 11'h1f4);
    commit_wait();
    reg_rd(amt_pkg::ADDR_GEFF1, 8'h7d);
    reg_rd(amt_pkg::ADDR_GEFF2, 8'h83);
    press(K_MODE, 1);
    check(active, 1'b0);
    reg_wr(amt_pkg::ADDR_OFS1, 8'h55);
    reg_rd(amt_pkg::ADDR_OFS1, 8'h01);
  endtask : t_gain

  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_refuse();
    t_offset();
    t_gain();
    test_done();
  end

  // Whole run needs about 8100 cycles
  initial begin
    repeat (40000) @(posedge clk);
    n_fail++;
    test_done();
  end
endmodule : tb

// ---- hdl/amt_key_sync.sv ----
/*
  Key input synchroniser with single-cycle press pulse.
  Assumes keys arrive asynchronously from the keypad.
*/
`timescale 1ns/1ps
module amt_key_sync #(
  parameter int N = 5
) (
  input  wire logic         core_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [N-1:0] key_i,
  output logic      [N-1:0] press_o
);
  logic [N-1:0] s1_reg, s2_reg, s3_reg;
  logic [N-1:0] stable_reg, stable_next;
  logic [N-1:0] press_reg, press_next;

  always_comb begin
    stable_next = stable_reg;
    press_next  = '0;
    for (int i = 0; i < N; i++) begin
      // Accept a change only when the second and third stage agree
      if (s2_reg[i] == s3_reg[i]) begin
        stable_next[i] = s3_reg[i];
        press_next[i]  = s3_reg[i] & ~stable_reg[i];
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_reg     <= '0;
      s2_reg     <= '0;
      s3_reg     <= '0;
      stable_reg <= '0;
      press_reg  <= '0;
    end else begin
      s1_reg     <= key_i;
      s2_reg     <= s1_reg;
      s3_reg     <= s2_reg;
      stable_reg <= stable_next;
      press_reg  <= press_next;
    end
  end

  assign press_o = press_reg;
endmodule : amt_key_sync

// ---- hdl/amt_pkg.sv ----
/*
  Constants and types for the analog monitor trim block.
  Assumes a single 25 MHz core clock.
*/
package amt_pkg;
  localparam int unsigned CLK_HZ          = 25000000;
  localparam int unsigned DONE_TIME_MS    = 1000;
  localparam int unsigned DONE_CYCLES     = CLK_HZ / 1000 * DONE_TIME_MS;
  localparam int unsigned TRIM_W          = 8;
  // Offset span +/-2.4 V at 18.9 mV per count
  localparam int          OFFSET_UV_LSB   = 18900;
  localparam int          OFFSET_MAX      = 127;
  localparam int          OFFSET_MIN      = -127;
  // Gain 100 % +/- 50 % at 0.4 % per count
  localparam int          GAIN_PERMIL_LSB = 4;
  localparam int          GAIN_MAX        = 125;
  localparam int          GAIN_MIN        = -125;
  localparam int unsigned GAIN_NOMINAL    = 1000;
  localparam logic [3:0]  WRITE_PERMIT_CODE = 4'h0;
  // Reg port map
  localparam logic [3:0]  ADDR_CTRL       = 4'h0;
  localparam logic [3:0]  ADDR_STATUS     = 4'h1;
  localparam logic [3:0]  ADDR_OFS1       = 4'h2;
  localparam logic [3:0]  ADDR_OFS2       = 4'h3;
  localparam logic [3:0]  ADDR_GAIN1      = 4'h4;
  localparam logic [3:0]  ADDR_GAIN2      = 4'h5;
  localparam logic [3:0]  ADDR_GEFF1      = 4'h6;
  localparam logic [3:0]  ADDR_GEFF2      = 4'h7;
  // Factory values, arbitrary neutral defaults
  localparam logic [7:0]  OFS1_FACTORY    = 8'h00;
  localparam logic [7:0]  OFS2_FACTORY    = 8'h00;
  localparam logic [7:0]  GAIN1_FACTORY   = 8'h00;
  localparam logic [7:0]  GAIN2_FACTORY   = 8'h00;
  typedef enum logic [1:0] {FN_NONE, FN_OFFSET, FN_GAIN} amt_fn_type;
  typedef enum {ST_MENU, ST_EDIT, ST_DONE} amt_state_type;
endpackage : amt_pkg

// ---- hdl/amt_trim.sv ----
/*
  Analog monitor offset and gain trim, edited from the operator keypad.
  Assumes keypad keys are asynchronous levels (high while pressed), and that
  software or the display reads state over the plain register port.
*/
`timescale 1ns/1ps
// Overview of operation
// - Each channel has a signed offset, 18.9 mV per count, about +/-2.4 V.
// - Each channel has a signed gain trim, 0.4 % per count, 50 to 150 %.
// - Effective gain is 100 % plus setting times 0.4 %.
// - Offsets and gains start from the factory values, neutral defaults.
// - Editing is entered only when write protect holds the permit code.
// - Parameter initialization leaves trim values untouched.
// - Data key on a trim menu entry opens its edit screen.
// - Channel one is force monitor, two is speed; cursor starts on one.
// - Up or down steps the selected channel; output follows at once.
// - Scroll moves the cursor from channel one to channel two.
// - Data key commits both values, shows done one second, then base block.
// - Mode/set key leaves the function back to the utility menu.
module amt_trim #(
  parameter int unsigned DONE_CYCLES = amt_pkg::DONE_CYCLES
) (
  input  wire logic       core_clk_i,
  input  wire logic       nrst_i,
  input  wire logic       key_up_i,
  input  wire logic       key_down_i,
  input  wire logic       key_scroll_i,
  input  wire logic       key_data_i,
  input  wire logic       key_modeset_i,
  input  wire logic [3:0] write_protect_setting_i,
  input  wire logic       parameter_init_i,
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  output logic      [7:0] force_offset_o,
  output logic      [7:0] speed_offset_o,
  output logic     [10:0] force_gain_permil_o,
  output logic     [10:0] speed_gain_permil_o,
  output logic            edit_active_o,
  output logic      [1:0] edit_function_o,
  output logic            cursor_o,
  output logic            done_indication_o,
  output logic            base_block_indication_o,
  output logic            commit_pulse_o
);
  localparam int unsigned CW = $clog2(DONE_CYCLES + 1);

  logic rst_a_reg, rst_b_reg;
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_a_reg <= 1'b0;
      rst_b_reg <= 1'b0;
    end else begin
      rst_a_reg <= 1'b1;
      rst_b_reg <= rst_a_reg;
    end
  end
  wire rst_n = rst_b_reg;

  logic [4:0] press;
  amt_key_sync #(.N(5)) u_keys (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n),
    .key_i      ({key_modeset_i, key_data_i, key_scroll_i, key_down_i, key_up_i}),
    .press_o    (press)
  );
  wire up_p   = press[0];
  wire down_p = press[1];
  wire scr_p  = press[2];
  wire data_p = press[3];
  wire mode_p = press[4];

  // Saturating step, shared by offset and gain
  function automatic logic [7:0] amt_step(input logic [7:0] v, input logic up, input logic dn,
                                           input int lo, input int hi);
    int s;
    s = $signed(v);
    if (up && s < hi) s = s + 1;
    else if (dn && s > lo) s = s - 1;
    return s[7:0];
  endfunction : amt_step

  function automatic logic [10:0] amt_gain(input logic [7:0] g);
    int p;
    // Casts keep the sum signed so a negative setting is sign-extended
    p = int'(amt_pkg::GAIN_NOMINAL) + int'($signed(g)) * amt_pkg::GAIN_PERMIL_LSB;
    return p[10:0];
  endfunction : amt_gain

  amt_pkg::amt_state_type state_reg, state_next;
  amt_pkg::amt_fn_type    fn_reg, fn_next;
  logic [1:0]  menu_reg, menu_next;
  logic        cur_reg, cur_next;
  logic [7:0]  ofs_reg [2], ofs_next [2];
  logic [7:0]  gain_reg [2], gain_next [2];
  logic [7:0]  nv_ofs_reg [2], nv_ofs_next [2];
  logic [7:0]  nv_gain_reg [2], nv_gain_next [2];
  logic [CW-1:0] cnt_reg, cnt_next;
  logic        commit_reg, commit_next;
  logic        refused_reg, refused_next;
  logic [7:0]  rdata_reg, rdata_next;

  wire permit = (write_protect_setting_i == amt_pkg::WRITE_PERMIT_CODE);

  always_comb begin
    state_next   = state_reg;
    fn_next      = fn_reg;
    menu_next    = menu_reg;
    cur_next     = cur_reg;
    ofs_next     = ofs_reg;
    gain_next    = gain_reg;
    nv_ofs_next  = nv_ofs_reg;
    nv_gain_next = nv_gain_reg;
    cnt_next     = cnt_reg;
    commit_next  = 1'b0;
    refused_next = refused_reg;
    // Menu selection written over the register port; parameter_init_i is
    // deliberately not read here so trims survive it
    if (wr_i && addr_i == amt_pkg::ADDR_CTRL) begin
      menu_next = wdata_i[1:0];
      if (wdata_i[7]) refused_next = 1'b0;
    end
    case (state_reg)
      amt_pkg::ST_MENU: begin
        if (data_p && menu_reg != 2'(amt_pkg::FN_NONE)) begin
          if (permit) begin
            state_next = amt_pkg::ST_EDIT;
            fn_next    = amt_pkg::amt_fn_type'(menu_reg);
            cur_next   = 1'b0;
          end else begin
            refused_next = 1'b1;
          end
        end
      end
      amt_pkg::ST_EDIT: begin
        if (mode_p) begin
          state_next = amt_pkg::ST_MENU;
          fn_next    = amt_pkg::FN_NONE;
        end else if (data_p) begin
          nv_ofs_next  = ofs_reg;
          nv_gain_next = gain_reg;
          commit_next  = 1'b1;
          cnt_next     = CW'(DONE_CYCLES - 1);
          state_next   = amt_pkg::ST_DONE;
        end else if (scr_p) begin
          cur_next = 1'b1;
        end else if (up_p || down_p) begin
          if (fn_reg == amt_pkg::FN_OFFSET)
            ofs_next[cur_reg] = amt_step(ofs_reg[cur_reg], up_p, down_p,
                                         amt_pkg::OFFSET_MIN, amt_pkg::OFFSET_MAX);
          else
            gain_next[cur_reg] = amt_step(gain_reg[cur_reg], up_p, down_p,
                                          amt_pkg::GAIN_MIN, amt_pkg::GAIN_MAX);
        end
      end
      amt_pkg::ST_DONE: begin
        if (cnt_reg == '0) state_next = amt_pkg::ST_EDIT;
        else cnt_next = cnt_reg - CW'(1);
      end
      default: state_next = amt_pkg::ST_MENU;
    endcase
  end

  always_comb begin
    rdata_next = 8'h00;
    if (rd_i) begin
      case (addr_i)
        amt_pkg::ADDR_CTRL:   rdata_next = {refused_reg, 5'h00, menu_reg};
        amt_pkg::ADDR_STATUS: rdata_next = {3'h0, (state_reg == amt_pkg::ST_DONE),
                                            cur_reg, (state_reg != amt_pkg::ST_MENU), fn_reg};
        amt_pkg::ADDR_OFS1:   rdata_next = ofs_reg[0];
        amt_pkg::ADDR_OFS2:   rdata_next = ofs_reg[1];
        amt_pkg::ADDR_GAIN1:  rdata_next = gain_reg[0];
        amt_pkg::ADDR_GAIN2:  rdata_next = gain_reg[1];
        amt_pkg::ADDR_GEFF1:  rdata_next = nv_gain_reg[0];
        amt_pkg::ADDR_GEFF2:  rdata_next = nv_gain_reg[1];
        default:              rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg   <= amt_pkg::ST_MENU;
      fn_reg      <= amt_pkg::FN_NONE;
      menu_reg    <= 2'h0;
      cur_reg     <= 1'b0;
      ofs_reg[0]  <= amt_pkg::OFS1_FACTORY;
      ofs_reg[1]  <= amt_pkg::OFS2_FACTORY;
      gain_reg[0] <= amt_pkg::GAIN1_FACTORY;
      gain_reg[1] <= amt_pkg::GAIN2_FACTORY;
      nv_ofs_reg[0]  <= amt_pkg::OFS1_FACTORY;
      nv_ofs_reg[1]  <= amt_pkg::OFS2_FACTORY;
      nv_gain_reg[0] <= amt_pkg::GAIN1_FACTORY;
      nv_gain_reg[1] <= amt_pkg::GAIN2_FACTORY;
      cnt_reg     <= '0;
      commit_reg  <= 1'b0;
      refused_reg <= 1'b0;
      rdata_reg   <= 8'h00;
    end else begin
      state_reg   <= state_next;
      fn_reg      <= fn_next;
      menu_reg    <= menu_next;
      cur_reg     <= cur_next;
      ofs_reg     <= ofs_next;
      gain_reg    <= gain_next;
      nv_ofs_reg  <= nv_ofs_next;
      nv_gain_reg <= nv_gain_next;
      cnt_reg     <= cnt_next;
      commit_reg  <= commit_next;
      refused_reg <= refused_next;
      rdata_reg   <= rdata_next;
    end
  end

  assign rdata_o                 = rdata_reg;
  assign force_offset_o          = ofs_reg[0];
  assign speed_offset_o          = ofs_reg[1];
  assign force_gain_permil_o     = amt_gain(gain_reg[0]);
  assign speed_gain_permil_o     = amt_gain(gain_reg[1]);
  assign edit_active_o           = (state_reg != amt_pkg::ST_MENU);
  assign edit_function_o         = fn_reg;
  assign cursor_o                = cur_reg;
  assign done_indication_o       = (state_reg == amt_pkg::ST_DONE);
  assign base_block_indication_o = (state_reg != amt_pkg::ST_DONE);
  assign commit_pulse_o          = commit_reg;

  // Helper: the done window length
  logic [CW-1:0] dlen_reg;
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) dlen_reg <= '0;
    else if (state_reg == amt_pkg::ST_DONE) dlen_reg <= dlen_reg + CW'(1);
    else dlen_reg <= '0;
  end

  entry_guard_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (state_reg == amt_pkg::ST_MENU && state_next == amt_pkg::ST_EDIT) |-> permit)
    else $error("Edit entered while write protected");
  cursor_start_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    $rose(edit_active_o) |-> !cursor_o)
    else $error("Cursor did not start on channel one");
  scroll_move_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (state_reg == amt_pkg::ST_EDIT && scr_p && !data_p && !mode_p) |=> cursor_o)
    else $error("Scroll did not move cursor");
  offset_range_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    $signed(ofs_reg[cur_reg]) <= amt_pkg::OFFSET_MAX && $signed(ofs_reg[cur_reg]) >= amt_pkg::OFFSET_MIN)
    else $error("Offset out of range");
  gain_range_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    $signed(gain_reg[0]) <= amt_pkg::GAIN_MAX && $signed(gain_reg[0]) >= amt_pkg::GAIN_MIN)
    else $error("Gain out of range");
  commit_save_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    commit_pulse_o |-> (nv_ofs_reg[0] == ofs_reg[0] && nv_gain_reg[1] == gain_reg[1] && done_indication_o))
    else $error("Commit did not store values");
  done_time_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    $fell(done_indication_o) |-> dlen_reg == CW'(DONE_CYCLES))
    else $error("Done indication length wrong");
  mode_exit_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (state_reg == amt_pkg::ST_EDIT && mode_p) |=> !edit_active_o)
    else $error("Mode key did not leave edit");
  step_up_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (state_reg == amt_pkg::ST_EDIT && fn_reg == amt_pkg::FN_OFFSET && up_p && !down_p && !scr_p
     && !data_p && !mode_p && !cur_reg && $signed(ofs_reg[0]) < amt_pkg::OFFSET_MAX)
    |=> $signed(force_offset_o) == $signed($past(force_offset_o)) + 1)
    else $error("Up key did not step offset");
  init_keep_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (parameter_init_i && state_reg == amt_pkg::ST_MENU) |=> $stable(nv_gain_reg[0]) && $stable(nv_ofs_reg[0]))
    else $error("Init changed trim values");
endmodule : amt_trim
